// ### hdl/hwm_regs.sv
// Limit, identity, over-temperature, fan pin and beep register slice of a hardware monitor, APB slave
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
// Functional notes
// - Indices 60h-7Fh mirror 20h-3Fh; accepted data-port accesses there advance the index.
// - Hold -12V low, -5V high/low, temp1 high/hysteresis, fan1/fan2 limits; 3Dh-3Fh reserved.
// - Fan limit is lowest-speed count; a measured count above it is a fan fault.
// - All-ones voltage/fan high limit or 7Fh temperature high limit never interrupts.
// - Index 49h bits 7-1 give a read-only device identity; bit 0 reads zero.
// - Index 4Ch bit 6 high selects comparator mode for the temperature-2 interrupt.
// - With bit 6 low, bit 5 picks one-time (1) or two-times (0) interrupt.
// - Index 4Ch bit 3 high suppresses the over-temperature output.
// - Index 4Ch bit 2 sets over-temperature polarity: 1 active high, 0 active low.
// - Index 4Dh resets to 15h; bit 2 low makes fan 2 pin output bit 3.
// - Bit 0 low makes fan 1 pin an output driving bit 1.
// - Index 4Eh bit 7 picks high (1) or low (0) vendor identity byte.
// - Index 4Eh bits 2-0 choose the bank answering at indices 50h-5Fh.
// - Index 4Fh returns the vendor identity byte; no index advance there.
// - Index 56h holds per-source beep enables for fans, temperatures and supplies.
// - Index 57h bit 7 is the global beep enable, reset 1.
// - Index 57h bits 4,2,1,0 enable case, -5V, -12V, +12V beeps, reset 0.
// - Status 41h/42h show each source's violation; 41h bits 7,6 are fan faults.
// - A set mask bit keeps its status bit off the management interrupt.
module hwm_regs #(
	// Identity values are arbitrary
	parameter logic [6:0] DEVICE_IDENTITY = 7'h15,
	parameter logic [15:0] VENDOR_IDENTITY = 16'h1234
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire hwm_pkg::hwm_meas_s MEAS,
	input wire hwm_pkg::hwm_flags_s EXT_FLAGS,
	input wire logic FAN1_IN,
	output logic FAN1_OUT,
	output logic FAN1_OE,
	input wire logic FAN2_IN,
	output logic FAN2_OUT,
	output logic FAN2_OE,
	output logic [1:0] FAN_TACH,
	output logic OVERTEMP_OUT,
	output logic OVERTEMP_OE,
	output logic MGMT_IRQ_OUT,
	output logic BEEP_OUT,
	output logic [2:0] BANK_NUMBER
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [6:0] fold_index(input logic [6:0] idx);
		fold_index = (idx[6:5] == 2'b11) ? {2'b01, idx[4:0]} : idx;
	endfunction

	function automatic logic in_range(input logic [6:0] idx, input logic [6:0] lo, input logic [6:0] hi);
		in_range = (idx >= lo) && (idx <= hi);
	endfunction

	// A high limit of all ones switches its comparison off
	function automatic logic over_high(input logic [7:0] value, input logic [7:0] limit);
		over_high = (limit != hwm_pkg::LIMIT_ALL_ONES) && (value > limit);
	endfunction

	// ****************************************
	// State
	// ****************************************
	logic [7:0] lim [0:hwm_pkg::LIMIT_COUNT-1];
	logic [7:0] irq_prop;
	logic [7:0] fan_ctl;
	logic [7:0] bank_sel;
	logic [7:0] beep_one;
	logic [7:0] beep_two;
	logic [7:0] mask_one;
	logic [7:0] mask_two;
	logic [6:0] port_index;
	logic temp1_hot;
	logic temp2_seen;
	logic temp2_event;
	logic [1:0] fan1_sync;
	logic [1:0] fan2_sync;

	// ****************************************
	// Bus decode
	// ****************************************
	logic setup_phase;
	logic access_phase;
	logic is_port_index;
	logic is_port_data;
	logic is_direct;
	logic [6:0] tgt_index;
	logic [6:0] eff_index;
	logic bank_zero;
	logic tgt_mapped;
	logic tgt_hit;
	logic wr_hit;
	logic rd_hit;
	logic [7:0] wdata;
	logic [7:0] rd_byte;

	// Direct indices sit at index times four, below the index/data port pair
	assign setup_phase = PSEL & ~PENABLE;
	assign access_phase = PSEL & PENABLE;
	assign is_port_index = (PADDR == hwm_pkg::ADDR_PORT_INDEX);
	assign is_port_data = (PADDR == hwm_pkg::ADDR_PORT_DATA);
	assign is_direct = (PADDR[11:9] == 3'h0) && (PADDR[1:0] == 2'h0);
	assign tgt_index = is_port_data ? port_index : PADDR[8:2];
	assign eff_index = fold_index(tgt_index);
	assign bank_zero = (bank_sel[2:0] == 3'h0);
	assign wdata = PWDATA[7:0];

	// Writes to read-only indices are taken and dropped without an error
	always_comb begin
		tgt_mapped = 1'b0;
		if (in_range(eff_index, hwm_pkg::IDX_NEG12V_LOW, hwm_pkg::IDX_VALUE_TOP)) begin
			tgt_mapped = 1'b1;
		end
		if (in_range(eff_index, hwm_pkg::IDX_STATUS_ONE, hwm_pkg::IDX_MASK_TWO)) begin
			tgt_mapped = 1'b1;
		end
		if (eff_index == hwm_pkg::IDX_DEVICE_IDENTITY) begin
			tgt_mapped = 1'b1;
		end
		if (in_range(eff_index, hwm_pkg::IDX_IRQ_PROP, hwm_pkg::IDX_VENDOR_IDENTITY)) begin
			tgt_mapped = 1'b1;
		end
		// Other banks live outside this slice, so they answer with an error here
		if (bank_zero && in_range(eff_index, hwm_pkg::IDX_BEEP_ONE, hwm_pkg::IDX_BEEP_TWO)) begin
			tgt_mapped = 1'b1;
		end
	end

	assign tgt_hit = (is_direct | is_port_data) & tgt_mapped;
	assign wr_hit = access_phase & PWRITE & tgt_hit;
	assign rd_hit = access_phase & ~PWRITE & tgt_hit;

	// Zero wait states: read data is captured in the setup cycle
	assign PREADY = 1'b1;
	assign PSLVERR = access_phase & ~(is_port_index | tgt_hit);

	// ****************************************
	// Monitoring
	// ****************************************
	logic fan1_fault;
	logic fan2_fault;
	logic neg5v_viol;
	logic neg12v_viol;
	logic temp2_status;
	logic [7:0] status_one;
	logic [7:0] status_two;
	logic [7:0] beep_src_one;
	logic [7:0] beep_src_two;
	logic temp2_rise;
	logic temp2_fall;
	logic next_temp2_event;
	logic overtemp_active;

	// Fan counts grow as a fan slows, so a count above the limit is a fault
	assign fan1_fault = over_high(MEAS.fan1, lim[5]);
	assign fan2_fault = over_high(MEAS.fan2, lim[6]);
	assign neg5v_viol = over_high(MEAS.neg5v, lim[1])
		| (MEAS.neg5v < lim[2]);
	// The -12V high limit lives below this slice, so its violation arrives as a flag
	assign neg12v_viol = EXT_FLAGS.neg12v_high | (MEAS.neg12v < lim[0]);

	// Temperature 1 trips above the high limit and releases below hysteresis
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			temp1_hot <= 1'b0;
		end else if (lim[3] == hwm_pkg::TEMP_NEVER) begin
			temp1_hot <= 1'b0;
		end else if ($signed(MEAS.temp1) > $signed(lim[3])) begin
			temp1_hot <= 1'b1;
		end else if ($signed(MEAS.temp1) < $signed(lim[4])) begin
			temp1_hot <= 1'b0;
		end
	end

	// Temperature 2 interrupt modes
	assign temp2_rise = EXT_FLAGS.temp2 & ~temp2_seen;
	assign temp2_fall = ~EXT_FLAGS.temp2 & temp2_seen;

	always_comb begin
		next_temp2_event = temp2_event;
		if (rd_hit && (eff_index == hwm_pkg::IDX_STATUS_ONE)) begin
			next_temp2_event = 1'b0;
		end
		// Set wins over the clear by read
		if (temp2_rise || (temp2_fall && !irq_prop[hwm_pkg::BIT_ONE_TIME])) begin
			next_temp2_event = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			temp2_seen <= 1'b0;
			temp2_event <= 1'b0;
		end else begin
			temp2_seen <= EXT_FLAGS.temp2;
			temp2_event <= next_temp2_event;
		end
	end

	assign temp2_status = irq_prop[hwm_pkg::BIT_COMPARATOR] ? EXT_FLAGS.temp2 : temp2_event;

	// ****************************************
	// Status, interrupt and beep
	// ****************************************
	assign status_one = {fan2_fault, fan1_fault, temp2_status, temp1_hot,
		EXT_FLAGS.analog_supply_input, EXT_FLAGS.v3p3, 1'b0, EXT_FLAGS.core_voltage_input};
	assign status_two = {3'h0, EXT_FLAGS.case_open, 1'b0, neg5v_viol, neg12v_viol, EXT_FLAGS.pos12v};

	assign beep_src_one = {fan2_fault, fan1_fault, EXT_FLAGS.temp2, temp1_hot,
		EXT_FLAGS.analog_supply_input, EXT_FLAGS.v3p3, 1'b0, EXT_FLAGS.core_voltage_input};
	assign beep_src_two = {3'h0, EXT_FLAGS.case_open, 1'b0, neg5v_viol, neg12v_viol, EXT_FLAGS.pos12v};

	assign overtemp_active = EXT_FLAGS.overtemp2 & ~irq_prop[hwm_pkg::BIT_OVT_DISABLE];

	// Registered so the interrupt pin cannot glitch while status settles
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			MGMT_IRQ_OUT <= 1'b0;
		end else begin
			MGMT_IRQ_OUT <= (|(status_one & ~mask_one)) | (|(status_two & ~mask_two));
		end
	end

	// Global enable gates last, so clearing it silences every source at once
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			BEEP_OUT <= 1'b0;
		end else begin
			BEEP_OUT <= beep_two[hwm_pkg::BIT_GLOBAL_BEEP]
				& ((|(beep_src_one & beep_one)) | (|(beep_src_two & beep_two[6:0])));
		end
	end

	// A disabled pin is released and still held at its inactive level
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			OVERTEMP_OUT <= 1'b1;
			OVERTEMP_OE <= 1'b0;
		end else begin
			OVERTEMP_OUT <= irq_prop[hwm_pkg::BIT_OVT_POLARITY] ? overtemp_active : ~overtemp_active;
			OVERTEMP_OE <= ~irq_prop[hwm_pkg::BIT_OVT_DISABLE];
		end
	end

	// ****************************************
	// Fan pins
	// ****************************************
	// Pins are asynchronous, so two flops stand before the tach logic
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			fan1_sync <= 2'h0;
			fan2_sync <= 2'h0;
		end else begin
			fan1_sync <= {fan1_sync[0], FAN1_IN};
			fan2_sync <= {fan2_sync[0], FAN2_IN};
		end
	end

	assign FAN1_OE = ~fan_ctl[hwm_pkg::BIT_FAN1_IS_INPUT];
	assign FAN1_OUT = fan_ctl[hwm_pkg::BIT_FAN1_OUT];
	assign FAN2_OE = ~fan_ctl[hwm_pkg::BIT_FAN2_IS_INPUT];
	assign FAN2_OUT = fan_ctl[hwm_pkg::BIT_FAN2_OUT];
	// Tach edges only reach the counter while the pin is an input
	assign FAN_TACH = {fan2_sync[1] & fan_ctl[hwm_pkg::BIT_FAN2_IS_INPUT],
		fan1_sync[1] & fan_ctl[hwm_pkg::BIT_FAN1_IS_INPUT]};
	assign BANK_NUMBER = bank_sel[2:0];

	// ****************************************
	// Register writes
	// ****************************************
	// Limit reset values are local choices; software loads real limits at start-up
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			for (int i = 0; i < hwm_pkg::LIMIT_COUNT; i++) begin
				lim[i] <= hwm_pkg::LIMIT_RST[i*8 +: 8];
			end
		end else if (wr_hit) begin
			for (int i = 0; i < hwm_pkg::LIMIT_COUNT; i++) begin
				if (eff_index == 7'(hwm_pkg::IDX_NEG12V_LOW + i)) begin
					lim[i] <= wdata;
				end
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			irq_prop <= hwm_pkg::IRQ_PROP_RST;
			fan_ctl <= hwm_pkg::FAN_CTL_RST;
			bank_sel <= hwm_pkg::BANK_SEL_RST;
			beep_one <= hwm_pkg::BEEP_ONE_RST;
			beep_two <= hwm_pkg::BEEP_TWO_RST;
			mask_one <= hwm_pkg::MASK_RST;
			mask_two <= hwm_pkg::MASK_RST;
		end else if (wr_hit) begin
			unique case (eff_index)
				hwm_pkg::IDX_IRQ_PROP: irq_prop <= wdata & hwm_pkg::IRQ_PROP_WMASK;
				hwm_pkg::IDX_FAN_CTL: fan_ctl <= wdata & hwm_pkg::FAN_CTL_WMASK;
				hwm_pkg::IDX_BANK_SEL: bank_sel <= wdata & hwm_pkg::BANK_SEL_WMASK;
				hwm_pkg::IDX_BEEP_ONE: beep_one <= wdata & hwm_pkg::BEEP_ONE_WMASK;
				hwm_pkg::IDX_BEEP_TWO: beep_two <= wdata & hwm_pkg::BEEP_TWO_WMASK;
				hwm_pkg::IDX_MASK_ONE: mask_one <= wdata;
				hwm_pkg::IDX_MASK_TWO: mask_two <= wdata & hwm_pkg::MASK_TWO_WMASK;
				default: ;
			endcase
		end
	end

	// Index port; only data accesses in the mirror range advance it, wrapping to its start
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			port_index <= hwm_pkg::PORT_INDEX_RST;
		end else if (access_phase && is_port_index && PWRITE) begin
			port_index <= PWDATA[6:0];
		end else if (access_phase && is_port_data && tgt_hit && (port_index[6:5] == 2'b11)) begin
			port_index <= (port_index == hwm_pkg::IDX_AUTO_LAST) ? hwm_pkg::IDX_AUTO_FIRST
				: 7'(port_index + 7'h01);
		end
	end

	// ****************************************
	// Register reads
	// ****************************************
	// Reserved indices 3Dh-3Fh and unused bits read as zero
	always_comb begin
		rd_byte = 8'h00;
		if (in_range(eff_index, hwm_pkg::IDX_NEG12V_LOW, hwm_pkg::IDX_FAN2_LIMIT)) begin
			rd_byte = lim[3'(eff_index - hwm_pkg::IDX_NEG12V_LOW)];
		end
		unique case (eff_index)
			hwm_pkg::IDX_STATUS_ONE: rd_byte = status_one;
			hwm_pkg::IDX_STATUS_TWO: rd_byte = status_two;
			hwm_pkg::IDX_MASK_ONE: rd_byte = mask_one;
			hwm_pkg::IDX_MASK_TWO: rd_byte = mask_two;
			hwm_pkg::IDX_DEVICE_IDENTITY: rd_byte = {DEVICE_IDENTITY, 1'b0};
			hwm_pkg::IDX_IRQ_PROP: rd_byte = irq_prop;
			hwm_pkg::IDX_FAN_CTL: rd_byte = fan_ctl;
			hwm_pkg::IDX_BANK_SEL: rd_byte = bank_sel;
			hwm_pkg::IDX_VENDOR_IDENTITY: rd_byte = bank_sel[hwm_pkg::BIT_HIGH_BYTE] ? VENDOR_IDENTITY[15:8]
				: VENDOR_IDENTITY[7:0];
			hwm_pkg::IDX_BEEP_ONE: rd_byte = beep_one;
			hwm_pkg::IDX_BEEP_TWO: rd_byte = beep_two;
			default: ;
		endcase
	end

	// A refused read returns zero, so another bank's data never leaks out
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			PRDATA <= 32'h00000000;
		end else if (setup_phase && !PWRITE) begin
			if (is_port_index) begin
				PRDATA <= {25'h0000000, port_index};
			end else if (tgt_hit) begin
				PRDATA <= {24'h000000, rd_byte};
			end else begin
				PRDATA <= 32'h00000000;
			end
		end
	end

endmodule

// ### hdl/hwm_pkg.sv
// Package: register map, reset values and carrier types of the monitor limit and beep registers
package hwm_pkg;

	// ****************************************
	// Register indices (byte address is four times the index)
	// ****************************************
	localparam logic [6:0] IDX_NEG12V_LOW = 7'h36;
	localparam logic [6:0] IDX_NEG5V_HIGH = 7'h37;
	localparam logic [6:0] IDX_NEG5V_LOW = 7'h38;
	localparam logic [6:0] IDX_TEMP1_HIGH = 7'h39;
	localparam logic [6:0] IDX_TEMP1_HYST = 7'h3A;
	localparam logic [6:0] IDX_FAN1_LIMIT = 7'h3B;
	localparam logic [6:0] IDX_FAN2_LIMIT = 7'h3C;
	localparam logic [6:0] IDX_VALUE_TOP = 7'h3F;
	localparam logic [6:0] IDX_STATUS_ONE = 7'h41;
	localparam logic [6:0] IDX_STATUS_TWO = 7'h42;
	localparam logic [6:0] IDX_MASK_ONE = 7'h43;
	localparam logic [6:0] IDX_MASK_TWO = 7'h44;
	localparam logic [6:0] IDX_DEVICE_IDENTITY = 7'h49;
	localparam logic [6:0] IDX_IRQ_PROP = 7'h4C;
	localparam logic [6:0] IDX_FAN_CTL = 7'h4D;
	localparam logic [6:0] IDX_BANK_SEL = 7'h4E;
	localparam logic [6:0] IDX_VENDOR_IDENTITY = 7'h4F;
	localparam logic [6:0] IDX_BEEP_ONE = 7'h56;
	localparam logic [6:0] IDX_BEEP_TWO = 7'h57;
	localparam int LIMIT_COUNT = 7;

	// ****************************************
	// Index/data port byte addresses
	// ****************************************
	localparam logic [11:0] ADDR_PORT_INDEX = 12'h200;
	localparam logic [11:0] ADDR_PORT_DATA = 12'h204;
	localparam logic [6:0] IDX_AUTO_FIRST = 7'h60;
	localparam logic [6:0] IDX_AUTO_LAST = 7'h7F;
	localparam logic [6:0] PORT_INDEX_RST = 7'h00;

	// ****************************************
	// Reset values and writable-bit masks
	// ****************************************
	localparam logic [55:0] LIMIT_RST = 56'h00_FF_00_7F_00_FF_00;
	localparam logic [7:0] IRQ_PROP_RST = 8'h00;
	localparam logic [7:0] IRQ_PROP_WMASK = 8'hEC;
	localparam logic [7:0] FAN_CTL_RST = 8'h15;
	localparam logic [7:0] FAN_CTL_WMASK = 8'h0F;
	localparam logic [7:0] BANK_SEL_RST = 8'h80;
	localparam logic [7:0] BANK_SEL_WMASK = 8'h87;
	localparam logic [7:0] BEEP_ONE_RST = 8'h00;
	localparam logic [7:0] BEEP_ONE_WMASK = 8'hFD;
	localparam logic [7:0] BEEP_TWO_RST = 8'h80;
	localparam logic [7:0] BEEP_TWO_WMASK = 8'h97;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] MASK_TWO_WMASK = 8'h3F;
	localparam logic [7:0] LIMIT_ALL_ONES = 8'hFF;
	localparam logic [7:0] TEMP_NEVER = 8'h7F;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_COMPARATOR = 6;
	localparam int BIT_ONE_TIME = 5;
	localparam int BIT_OVT_DISABLE = 3;
	localparam int BIT_OVT_POLARITY = 2;
	localparam int BIT_FAN2_OUT = 3;
	localparam int BIT_FAN2_IS_INPUT = 2;
	localparam int BIT_FAN1_OUT = 1;
	localparam int BIT_FAN1_IS_INPUT = 0;
	localparam int BIT_HIGH_BYTE = 7;
	localparam int BIT_GLOBAL_BEEP = 7;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [7:0] neg12v;
		logic [7:0] neg5v;
		logic [7:0] temp1;
		logic [7:0] fan1;
		logic [7:0] fan2;
	} hwm_meas_s;

	typedef struct packed {
		logic core_voltage_input;
		logic v3p3;
		logic analog_supply_input;
		logic pos12v;
		logic neg12v_high;
		logic temp2;
		logic overtemp2;
		logic case_open;
	} hwm_flags_s;

endpackage

// ### bench/hwm_regs_checker.sv
// Checker: port-level assertions of the monitor register slice
`timescale 1ns/100ps
module hwm_regs_checker (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic PSLVERR,
	input wire logic FAN2_IN,
	input wire logic FAN1_OUT,
	input wire logic FAN1_OE,
	input wire logic FAN2_OUT,
	input wire logic FAN2_OE,
	input wire logic [1:0] FAN_TACH,
	input wire logic OVERTEMP_OE,
	input wire logic BEEP_OUT,
	input wire logic [2:0] BANK_NUMBER
);
	// ********
	// Helpers
	// ********
	logic [31:0] wd_q;
	always_ff @(posedge SYS_CLK) begin
		wd_q <= PWDATA;
	end
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);
	// Accepted write; an errored access changes nothing
	sequence s_wr(logic [6:0] idx);
		PSEL && PENABLE && PWRITE && !PSLVERR && PADDR == {3'h0, idx, 2'h0};
	endsequence
	sequence s_beep_off;
		s_wr(7'h57) ##0 !PWDATA[7];
	endsequence
	sequence s_ovt_off;
		s_wr(7'h4C) ##0 PWDATA[3];
	endsequence
	// ********
	// Assertions
	// ********
	a_fan1_drive: assert property (s_wr(7'h4D) |=> FAN1_OE == !wd_q[0] && FAN1_OUT == wd_q[1])
		else $error("fan 1 pin drive wrong");
	a_fan2_drive: assert property (s_wr(7'h4D) |=> FAN2_OE == !wd_q[2] && FAN2_OUT == wd_q[3])
		else $error("fan 2 pin drive wrong");
	a_tach_blocked: assert property (FAN1_OE [*4] |-> !FAN_TACH[0])
		else $error("tach seen while pin drives");
	a_tach_follow: assert property (!FAN2_OE [*4] |-> FAN_TACH[1] == $past(FAN2_IN, 2))
		else $error("tach does not follow pin");
	a_ovt_disable: assert property (s_ovt_off |-> ##2 !OVERTEMP_OE)
		else $error("over-temperature pin still enabled");
	a_bank_follow: assert property (s_wr(7'h4E) |=> BANK_NUMBER == wd_q[2:0])
		else $error("bank number wrong");
	a_beep_global: assert property (s_beep_off |-> ##2 !BEEP_OUT)
		else $error("beep with global enable off");
	a_bank_err: assert property (PSEL && PENABLE && BANK_NUMBER != 3'h0 && PADDR[11:3] == 9'h02B |-> PSLVERR)
		else $error("beep register answered outside bank 0");
endmodule

// ### bench/hwm_fan_model.sv
// Fan side model: tachometer pulses and resolved level on both fan pins
`timescale 1ns/100ps
module hwm_fan_model (
	input wire logic clk,
	input wire logic fan1_out,
	input wire logic fan1_oe,
	input wire logic fan2_out,
	input wire logic fan2_oe,
	output logic fan1_pin,
	output logic fan2_pin
);
	logic [3:0] rev_cnt = 4'h0;
	always_ff @(posedge clk) begin
		rev_cnt <= rev_cnt + 4'h1;
	end
	// Two speeds, so a swapped pin shows up
	assign fan1_pin = fan1_oe ? fan1_out : rev_cnt[2];
	assign fan2_pin = fan2_oe ? fan2_out : rev_cnt[3];
endmodule

// ### bench/hwm_regs_tb.sv
// Testbench: registers, pins, interrupt and beep of the monitor register slice
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module hwm_regs_tb;
	logic SYS_CLK = 1'h0;
	logic SYS_RST = 1'h1;
	logic PSEL = 1'h0;
	logic PENABLE = 1'h0;
	logic PWRITE = 1'h0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic PREADY, PSLVERR, FAN1_IN, FAN1_OUT, FAN1_OE, FAN2_IN, FAN2_OUT, FAN2_OE;
	logic OVERTEMP_OUT, OVERTEMP_OE, MGMT_IRQ_OUT, BEEP_OUT;
	logic [1:0] FAN_TACH;
	logic [2:0] BANK_NUMBER;
	hwm_pkg::hwm_meas_s MEAS = '0;
	hwm_pkg::hwm_flags_s EXT_FLAGS = '0;
	logic [31:0] rd;
	logic er;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	// ********
	// Rows: write, index, data, expected byte, expected error; first 15 are reset values; reserved bits 0
	// ********
	logic [31:0] rows [42] = '{32'h0_36_00_00_0, 32'h0_37_00_FF_0, 32'h0_38_00_00_0, 32'h0_39_00_7F_0,
		32'h0_3A_00_00_0, 32'h0_3B_00_FF_0, 32'h0_3C_00_00_0, 32'h0_49_00_54_0, 32'h0_4C_00_00_0,
		32'h0_4D_00_15_0, 32'h0_4E_00_80_0, 32'h0_4F_00_C3_0, 32'h0_56_00_00_0, 32'h0_57_00_80_0,
		32'h0_43_00_00_0, 32'h1_3B_A5_00_0, 32'h0_3B_00_A5_0, 32'h1_37_5A_00_0, 32'h0_37_00_5A_0,
		32'h1_3C_FF_00_0, 32'h0_3C_00_FF_0, 32'h1_4C_FF_00_0, 32'h0_4C_00_EC_0, 32'h1_4C_00_00_0,
		32'h1_4D_F5_00_0, 32'h0_4D_00_05_0, 32'h1_4E_05_00_0, 32'h0_4E_00_05_0, 32'h0_4F_00_E1_0,
		32'h0_56_00_00_1, 32'h1_4E_80_00_0, 32'h1_56_FF_00_0, 32'h0_56_00_FD_0, 32'h1_57_BF_00_0,
		32'h0_57_00_97_0, 32'h1_57_80_00_0, 32'h1_56_00_00_0, 32'h1_49_FF_00_0, 32'h0_49_00_54_0,
		32'h0_4A_00_00_1, 32'h1_3D_FF_00_0, 32'h0_3D_00_00_0};
	// Beep one, beep two, mask one, flags, fan counts, then expected beep and interrupt
	logic [55:0] beeps [8] = '{56'h08_80_00_20_00_00_11, 56'h00_80_08_20_00_00_00, 56'h08_00_00_20_00_00_01,
		56'h00_90_00_01_00_00_11, 56'h00_81_00_10_00_00_11, 56'h40_80_00_00_A6_00_11,
		56'h40_80_00_00_A5_00_00, 56'h80_80_00_00_00_FF_00};
	// Identity values are arbitrary
	hwm_regs #(.DEVICE_IDENTITY(7'h2A), .VENDOR_IDENTITY(16'hC3E1)) i_hwm_regs (.SYS_CLK, .SYS_RST, .PSEL, .PENABLE,
		.PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .MEAS, .EXT_FLAGS, .FAN1_IN, .FAN1_OUT, .FAN1_OE,
		.FAN2_IN, .FAN2_OUT, .FAN2_OE, .FAN_TACH, .OVERTEMP_OUT, .OVERTEMP_OE, .MGMT_IRQ_OUT, .BEEP_OUT,
		.BANK_NUMBER);
	hwm_fan_model i_hwm_fan_model (.clk(SYS_CLK), .fan1_out(FAN1_OUT), .fan1_oe(FAN1_OE), .fan2_out(FAN2_OUT),
		.fan2_oe(FAN2_OE), .fan1_pin(FAN1_IN), .fan2_pin(FAN2_IN));
	always #10 SYS_CLK = ~SYS_CLK;
	// Whole run is about 450 cycles
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			final_report();
		end
	end
	// ********
	// Tasks
	// ********
	function automatic logic [11:0] ba(input logic [6:0] i);
		return {3'h0, i, 2'h0};
	endfunction
	// Idle cycle after each transfer keeps strobes from being set twice at one edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		PSEL <= 1'h1;
		PENABLE <= 1'h0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= {24'h000000, d};
		@(posedge SYS_CLK);
		PENABLE <= 1'h1;
		do @(posedge SYS_CLK); while (PREADY !== 1'h1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge SYS_CLK);
	endtask
	task automatic do_reset();
		SYS_RST <= 1'h1;
		repeat (16) @(posedge SYS_CLK);
		SYS_RST <= 1'h0;
		@(posedge SYS_CLK);
	endtask
	task automatic run_rows(input int n);
		for (int k = 0; k < n; k++) begin
			apb(rows[k][28], ba(rows[k][26:20]), rows[k][19:12]);
			`CHK(er, rows[k][0])
			if (!rows[k][28]) `CHK(rd[7:0], rows[k][11:4])
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ********
	// Sequence
	// ********
	initial begin
		logic [55:0] b;
		logic [7:0] v;
		do_reset();
		run_rows(42);
		$display("register table done");
		for (int k = 0; k < 2; k++) begin
			v = 8'h0A >> (4 * k);
			apb(1'h1, ba(7'h4D), v);
			`CHK({FAN2_OE, FAN2_OUT, FAN1_OE, FAN1_OUT}, {~v[2], v[3], ~v[0], v[1]})
		end
		apb(1'h1, ba(7'h4D), 8'h15);
		$display("fan pins done");
		for (int k = 0; k < 8; k++) begin
			v = {4'h0, k[2:1], 2'h0};
			EXT_FLAGS.overtemp2 <= k[0];
			apb(1'h1, ba(7'h4C), v);
			repeat (2) @(posedge SYS_CLK);
			`CHK(OVERTEMP_OE, ~v[3])
			`CHK(OVERTEMP_OUT, (k[0] && !v[3]) ? v[2] : ~v[2])
		end
		$display("over-temperature done");
		EXT_FLAGS <= '0;
		// Comparator, one-time, then two-times (reserved bit 4 written)
		for (int k = 0; k < 3; k++) begin
			apb(1'h1, ba(7'h4C), 8'h40 >> k);
			EXT_FLAGS.temp2 <= 1'h1;
			repeat (4) @(posedge SYS_CLK);
			apb(1'h0, ba(7'h41), 8'h00);
			`CHK(rd[5], 1'h1)
			EXT_FLAGS.temp2 <= 1'h0;
			repeat (4) @(posedge SYS_CLK);
			`CHK(MGMT_IRQ_OUT, k == 2)
			apb(1'h0, ba(7'h41), 8'h00);
		end
		$display("interrupt modes done");
		for (int k = 0; k < 8; k++) begin
			b = beeps[k];
			apb(1'h1, ba(7'h56), b[55:48]);
			apb(1'h1, ba(7'h57), b[47:40]);
			apb(1'h1, ba(7'h43), b[39:32]);
			EXT_FLAGS <= b[31:24];
			MEAS <= {24'h000000, b[23:8]};
			repeat (4) @(posedge SYS_CLK);
			`CHK({BEEP_OUT, MGMT_IRQ_OUT}, {b[4], b[0]})
		end
		$display("beep done");
		apb(1'h1, 12'h200, 8'h7B);
		apb(1'h1, 12'h204, 8'hAA);
		apb(1'h1, 12'h204, 8'h55);
		apb(1'h0, ba(7'h3B), 8'h00);
		`CHK(rd[7:0], 8'hAA)
		apb(1'h0, ba(7'h3C), 8'h00);
		`CHK(rd[7:0], 8'h55)
		apb(1'h0, 12'h200, 8'h00);
		`CHK(rd[6:0], 7'h7D)
		apb(1'h1, 12'h200, 8'h7F);
		apb(1'h0, 12'h204, 8'h00);
		apb(1'h0, 12'h200, 8'h00);
		`CHK(rd[6:0], 7'h60)
		apb(1'h1, 12'h200, 8'h4F);
		apb(1'h0, 12'h204, 8'h00);
		`CHK(rd[7:0], 8'hC3)
		apb(1'h0, 12'h200, 8'h00);
		`CHK(rd[6:0], 7'h4F)
		$display("index port done");
		MEAS <= '0;
		EXT_FLAGS <= '0;
		do_reset();
		`CHK({BANK_NUMBER, FAN2_OE, FAN1_OE, BEEP_OUT, MGMT_IRQ_OUT, OVERTEMP_OUT, PREADY}, 9'h003)
		run_rows(15);
		`CHK(OVERTEMP_OE, 1'h1)
		$display("reset done");
		final_report();
	end
endmodule
bind hwm_regs hwm_regs_checker i_hwm_regs_checker (.SYS_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
	.PWDATA, .PSLVERR, .FAN2_IN, .FAN1_OUT, .FAN1_OE, .FAN2_OUT, .FAN2_OE, .FAN_TACH, .OVERTEMP_OE, .BEEP_OUT,
	.BANK_NUMBER);
